// File: design/qdpc_channel.sv
// One DAC channel: output load, range latch and output level in millivolts
`timescale 1ns/1ps
module qdpc_channel (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] code,
    input wire logic powered,
    input wire logic load_select,
    input wire logic range_pin,
    input wire logic update,
    output qdpc_pkg::qdpc_vout_s vout
);
    typedef struct packed {
        logic range_hi;
        qdpc_pkg::qdpc_vout_s vout;
    } qdpc_ch_s;

    qdpc_ch_s r;
    qdpc_ch_s n;
    logic [27:0] prod;

    always_comb begin
        n = r;
        // A new range only shows once the DAC register is written again
        if (update) begin
            n.range_hi = range_pin;
        end
        prod = 28'(code) * 28'(n.range_hi ? qdpc_pkg::RANGE_LO_MV
                                          : qdpc_pkg::RANGE_HI_MV);
        n.vout.mv = powered ? prod[qdpc_pkg::CODE_SHIFT +: 16] : 16'h0000;
        n.vout.drive = powered;
        n.vout.gnd_tie = !powered && load_select;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign vout = r.vout;
endmodule

// File: design/qdpc_pkg.sv
// Constants and carrier types of the quad DAC power control block
// Function
// - After reset the control register holds 0x40, so every channel starts powered down.
// - After reset all input and DAC registers hold 0x000 and keep it until a valid write.
// - The analog section is on whenever at least one channel power bit (bits 2 to 5) is 1.
// - Each channel powers up or down on its own bit while the digital logic keeps working.
// - A powered-down output is either floated or tied to ground, as the load select bit says.
// - Powering a channel down leaves its DAC register untouched.
// - DAC and input registers accept writes while channels are powered down.
// - The control register can be read back at any time.
// - There are four independent channels, each with its own DAC register and output.
// - Each output equals the straight-binary 12-bit code divided by 4096 times the range.
// - Range select high gives a 0 to 30 V span, low gives 0 to 60 V.
// - The host writes registers as 16-bit serial words.
// - A frame is a read/write flag, three select bits and 12 data bits, MSB first.
// - A write frame with all three select bits set goes to the control register.
// - A falling edge of the load strobe copies all input registers to the DAC registers at once; the code ignores the edge while clear is held low.
// - A falling edge of the clear input resets all input and DAC registers to 0x000.
package qdpc_pkg;
    localparam int NCH = 4;
    localparam int DW = 12;
    localparam logic [11:0] CTRL_RESET = 12'h040;
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam int PWR_LSB = 2;
    localparam int LOAD_SEL_BIT = 6;
    localparam logic [2:0] SEL_CTRL = 3'h7;
    localparam logic [2:0] SEL_CH_FIRST = 3'h1;
    localparam logic [4:0] FRAME_LAST = 5'h10;
    localparam logic [4:0] SDO_START_CNT = 5'h04;
    localparam int RW_AT_START = 3;
    localparam logic [15:0] RANGE_LO_MV = 16'h7530;
    localparam logic [15:0] RANGE_HI_MV = 16'hea60;
    localparam int CODE_SHIFT = 12;
    // APB byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_SER = 8'h0c;
    localparam logic [7:0] ADDR_INP = 8'h10;
    localparam logic [7:0] ADDR_DAC = 8'h20;
    localparam logic [7:0] ADDR_VOUT = 8'h30;
    localparam logic [7:0] ADDR_LAST = 8'h40;
    localparam logic [7:0] GROUP_MASK = 8'hf0;
    localparam int CMD_LOAD_BIT = 0;
    localparam int CMD_CLEAR_BIT = 1;
    // Register groups seen by the APB decoder
    localparam logic [2:0] G_NONE = 3'h0;
    localparam logic [2:0] G_CTRL = 3'h1;
    localparam logic [2:0] G_STAT = 3'h2;
    localparam logic [2:0] G_CMD = 3'h3;
    localparam logic [2:0] G_SER = 3'h4;
    localparam logic [2:0] G_INP = 3'h5;
    localparam logic [2:0] G_DAC = 3'h6;
    localparam logic [2:0] G_VOUT = 3'h7;

    typedef struct packed {
        logic rw;
        logic [2:0] sel;
        logic [11:0] data;
    } qdpc_frame_s;

    typedef struct packed {
        logic [15:0] mv;
        logic drive;
        logic gnd_tie;
    } qdpc_vout_s;
endpackage

// File: design/qdpc_serial_rx.sv
// Serial frame receiver with readback shifter of the quad DAC power control block
`timescale 1ns/1ps
module qdpc_serial_rx (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic frame_sync_n,
    input wire logic serial_clk,
    input wire logic serial_din,
    input wire logic [11:0] rd_word,
    output logic [2:0] rd_sel,
    output logic frame_valid,
    output logic frame_abort,
    output qdpc_pkg::qdpc_frame_s frame,
    output logic serial_dout,
    output logic serial_dout_oe
);
    typedef struct packed {
        logic [2:0] s0;
        logic [2:0] s1;
        logic sclk_prev;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic [11:0] out;
        logic oe;
        logic done;
        logic valid;
        logic abort;
        qdpc_pkg::qdpc_frame_s frame;
    } qdpc_rx_s;

    qdpc_rx_s r;
    qdpc_rx_s n;
    logic rise;
    logic fall;

    always_comb begin
        n = r;
        n.valid = 1'b0;
        n.abort = 1'b0;
        n.s0 = {frame_sync_n, serial_clk, serial_din};
        n.s1 = r.s0;
        n.sclk_prev = r.s1[1];
        rise = r.s1[1] & ~r.sclk_prev;
        fall = ~r.s1[1] & r.sclk_prev;
        if (r.s1[2]) begin
            // Sync high before the last falling edge drops the frame
            n.abort = (r.cnt != 5'h00) && !r.done;
            n.cnt = 5'h00;
            n.oe = 1'b0;
            n.done = 1'b0;
        end else begin
            if (rise && r.cnt != qdpc_pkg::FRAME_LAST) begin
                n.sh = {r.sh[14:0], r.s1[0]};
                n.cnt = r.cnt + 5'h01;
                if (r.oe) begin
                    n.out = {r.out[10:0], 1'b0};
                end
                if (r.cnt == qdpc_pkg::SDO_START_CNT && r.sh[qdpc_pkg::RW_AT_START]) begin
                    n.oe = 1'b1;
                    n.out = rd_word;
                end
            end
            if (fall && r.cnt == qdpc_pkg::FRAME_LAST && !r.done) begin
                n.valid = 1'b1;
                n.frame = r.sh;
                n.done = 1'b1;
                n.oe = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Sync high and clock low match the idle pins, so no false edge follows reset
            r <= '{s0: 3'h4, s1: 3'h4, default: '0};
        end else begin
            r <= n;
        end
    end

    assign rd_sel = r.sh[2:0];
    assign frame_valid = r.valid;
    assign frame_abort = r.abort;
    assign frame = r.frame;
    assign serial_dout = r.out[11];
    assign serial_dout_oe = r.oe;
endmodule

// File: design/qdpc_top.sv
// Top level of the quad DAC power control block with its APB register file
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module qdpc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_sync_n,
    input wire logic serial_clk,
    input wire logic serial_din,
    output logic serial_dout,
    output logic serial_dout_oe,
    input wire logic load_outputs_strobe_n,
    input wire logic clear_input_n,
    input wire logic range_select,
    output logic analog_on,
    output qdpc_pkg::qdpc_vout_s [3:0] vout
);
    typedef struct packed {
        logic [11:0] ctrl;
        logic [3:0][11:0] inp;
        logic [3:0][11:0] dac;
        logic [1:0] load_outputs_strobe_sync;
        logic load_outputs_strobe_prev;
        logic [1:0] clr_sync;
        logic clr_prev;
        logic [1:0] rsel_sync;
        logic [15:0] frames_ok;
        logic [15:0] frames_bad;
        logic [15:0] last_frame;
        logic ack;
        logic err;
        logic [31:0] rdata;
        logic analog_on;
    } qdpc_top_s;

    qdpc_top_s r;
    qdpc_top_s n;
    logic [3:0] upd;
    logic [2:0] grp;
    logic [1:0] idx;
    logic [2:0] rd_sel;
    logic [11:0] rd_word;
    logic frame_valid;
    logic frame_abort;
    qdpc_pkg::qdpc_frame_s frame;
    logic load_outputs_strobe_low;
    logic load_outputs_strobe_fall;
    logic clr_low;
    logic clr_fall;
    logic [2:0] fsel;
    logic [31:0] rd_val;

    // Maps a frame select code to {hit, channel}
    function automatic logic [2:0] chan_of(input logic [2:0] sel);
        logic [2:0] off;
        off = sel - qdpc_pkg::SEL_CH_FIRST;
        chan_of = {(sel >= qdpc_pkg::SEL_CH_FIRST) && (off < 3'h4), off[1:0]};
    endfunction

    function automatic logic [2:0] group_of(input logic [31:0] addr);
        logic [7:0] a;
        a = addr[7:0];
        group_of = qdpc_pkg::G_NONE;
        if (addr[31:8] != 24'h000000 || addr[1:0] != 2'h0) begin
            group_of = qdpc_pkg::G_NONE;
        end else if (a == qdpc_pkg::ADDR_CTRL) begin
            group_of = qdpc_pkg::G_CTRL;
        end else if (a == qdpc_pkg::ADDR_STAT) begin
            group_of = qdpc_pkg::G_STAT;
        end else if (a == qdpc_pkg::ADDR_CMD) begin
            group_of = qdpc_pkg::G_CMD;
        end else if (a == qdpc_pkg::ADDR_SER || a == qdpc_pkg::ADDR_LAST) begin
            group_of = qdpc_pkg::G_SER;
        end else if ((a & qdpc_pkg::GROUP_MASK) == qdpc_pkg::ADDR_INP) begin
            group_of = qdpc_pkg::G_INP;
        end else if ((a & qdpc_pkg::GROUP_MASK) == qdpc_pkg::ADDR_DAC) begin
            group_of = qdpc_pkg::G_DAC;
        end else if ((a & qdpc_pkg::GROUP_MASK) == qdpc_pkg::ADDR_VOUT) begin
            group_of = qdpc_pkg::G_VOUT;
        end
    endfunction

    // Byte lane merge of a 12-bit field sitting in the low bits of the word
    function automatic logic [11:0] merge12(input logic [11:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] strb);
        merge12 = old;
        if (strb[0]) begin
            merge12[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            merge12[11:8] = wd[11:8];
        end
    endfunction

    assign grp = group_of(paddr);
    assign idx = paddr[3:2];
    assign load_outputs_strobe_low = !r.load_outputs_strobe_sync[1];
    assign load_outputs_strobe_fall = r.load_outputs_strobe_prev && !r.load_outputs_strobe_sync[1];
    assign clr_low = !r.clr_sync[1];
    assign clr_fall = r.clr_prev && !r.clr_sync[1];
    assign fsel = chan_of(frame.sel);

    // Serial readback source
    always_comb begin
        logic [2:0] c;
        c = chan_of(rd_sel);
        rd_word = 12'h000;
        if (rd_sel == qdpc_pkg::SEL_CTRL) begin
            rd_word = r.ctrl;
        end else if (c[2]) begin
            rd_word = r.inp[c[1:0]];
        end
    end

    // APB read source
    always_comb begin
        rd_val = 32'h00000000;
        unique case (grp)
            qdpc_pkg::G_CTRL: rd_val = {20'h00000, r.ctrl};
            qdpc_pkg::G_STAT: rd_val = {24'h000000, clr_low, r.rsel_sync[1],
                                        r.ctrl[qdpc_pkg::LOAD_SEL_BIT], r.analog_on,
                                        r.ctrl[qdpc_pkg::PWR_LSB +: qdpc_pkg::NCH]};
            qdpc_pkg::G_CMD: rd_val = 32'h00000000;
            qdpc_pkg::G_SER: rd_val = (paddr[7:0] == qdpc_pkg::ADDR_LAST)
                                      ? {16'h0000, r.last_frame}
                                      : {r.frames_bad, r.frames_ok};
            qdpc_pkg::G_INP: rd_val = {20'h00000, r.inp[idx]};
            qdpc_pkg::G_DAC: rd_val = {20'h00000, r.dac[idx]};
            qdpc_pkg::G_VOUT: rd_val = {14'h0000, vout[idx]};
            qdpc_pkg::G_NONE: rd_val = 32'h00000000;
        endcase
    end

    always_comb begin
        n = r;
        upd = 4'h0;
        n.load_outputs_strobe_sync = {r.load_outputs_strobe_sync[0], load_outputs_strobe_n};
        n.load_outputs_strobe_prev = r.load_outputs_strobe_sync[1];
        n.clr_sync = {r.clr_sync[0], clear_input_n};
        n.clr_prev = r.clr_sync[1];
        n.rsel_sync = {r.rsel_sync[0], range_select};

        // One wait state so read data comes from a flip-flop
        n.ack = 1'b0;
        if (psel && penable && !r.ack) begin
            n.ack = 1'b1;
            n.err = (grp == qdpc_pkg::G_NONE);
            n.rdata = pwrite ? 32'h00000000 : rd_val;
        end

        if (psel && penable && r.ack && pwrite) begin
            unique case (grp)
                qdpc_pkg::G_CTRL: n.ctrl = merge12(r.ctrl, pwdata, pstrb);
                qdpc_pkg::G_INP: begin
                    n.inp[idx] = merge12(r.inp[idx], pwdata, pstrb);
                    if (load_outputs_strobe_low && !clr_low) begin
                        n.dac[idx] = n.inp[idx];
                        upd[idx] = 1'b1;
                    end
                end
                qdpc_pkg::G_CMD: begin
                    if (pstrb[0] && pwdata[qdpc_pkg::CMD_LOAD_BIT] && !clr_low) begin
                        n.dac = r.inp;
                        upd = 4'hf;
                    end
                    if (pstrb[0] && pwdata[qdpc_pkg::CMD_CLEAR_BIT]) begin
                        n.inp = '0;
                        n.dac = '0;
                        upd = 4'hf;
                    end
                end
                qdpc_pkg::G_STAT, qdpc_pkg::G_SER, qdpc_pkg::G_DAC,
                qdpc_pkg::G_VOUT, qdpc_pkg::G_NONE: begin
                end
            endcase
        end

        // Serial frames are applied after APB, so they win a same-cycle collision
        if (frame_valid) begin
            n.frames_ok = r.frames_ok + 16'h0001;
            n.last_frame = frame;
            if (!frame.rw) begin
                if (frame.sel == qdpc_pkg::SEL_CTRL) begin
                    n.ctrl = frame.data;
                end else if (fsel[2]) begin
                    n.inp[fsel[1:0]] = frame.data;
                    if (load_outputs_strobe_low && !clr_low) begin
                        n.dac[fsel[1:0]] = frame.data;
                        upd[fsel[1:0]] = 1'b1;
                    end
                end
            end
        end
        if (frame_abort) begin
            n.frames_bad = r.frames_bad + 16'h0001;
        end

        // Strobes are ignored while clear is held low
        if (load_outputs_strobe_fall && !clr_low) begin
            n.dac = n.inp;
            upd = 4'hf;
        end
        if (clr_fall) begin
            n.inp = '0;
            n.dac = '0;
            upd = 4'hf;
        end

        // Power bits gate the outputs only; DAC codes stay as they are
        n.analog_on = |n.ctrl[qdpc_pkg::PWR_LSB +: qdpc_pkg::NCH];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{ctrl: qdpc_pkg::CTRL_RESET,
                   inp: {4{qdpc_pkg::CODE_RESET}},
                   dac: {4{qdpc_pkg::CODE_RESET}},
                   load_outputs_strobe_sync: 2'h3, load_outputs_strobe_prev: 1'b1,
                   clr_sync: 2'h3, clr_prev: 1'b1,
                   default: '0};
        end else begin
            r <= n;
        end
    end

    qdpc_serial_rx u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .frame_sync_n(frame_sync_n),
        .serial_clk(serial_clk),
        .serial_din(serial_din),
        .rd_word(rd_word),
        .rd_sel(rd_sel),
        .frame_valid(frame_valid),
        .frame_abort(frame_abort),
        .frame(frame),
        .serial_dout(serial_dout),
        .serial_dout_oe(serial_dout_oe)
    );

    genvar gi;
    generate
        for (gi = 0; gi < qdpc_pkg::NCH; gi++) begin : g_ch
            qdpc_channel u_ch (
                .pclk(pclk),
                .presetn(presetn),
                .code(r.dac[gi]),
                .powered(r.ctrl[qdpc_pkg::PWR_LSB + gi]),
                .load_select(r.ctrl[qdpc_pkg::LOAD_SEL_BIT]),
                .range_pin(r.rsel_sync[1]),
                .update(upd[gi]),
                .vout(vout[gi])
            );
        end
    endgenerate

    assign prdata = r.rdata;
    assign pready = r.ack;
    assign pslverr = r.ack && r.err;
    assign analog_on = r.analog_on;
endmodule

// File: test/qdpc_asserts.sv
// Assertion checker watching the ports of the quad DAC power control top
`timescale 1ns/1ps
module qdpc_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic frame_sync_n,
    input wire logic serial_dout_oe,
    input wire logic clear_input_n,
    input wire logic analog_on,
    input wire qdpc_pkg::qdpc_vout_s [3:0] vout
);
    logic drv_any;
    logic mv_off_ok;
    logic tie_ok;
    logic mv_zero;

    always_comb begin
        drv_any = 1'b0;
        mv_off_ok = 1'b1;
        tie_ok = 1'b1;
        mv_zero = 1'b1;
        for (int i = 0; i < 4; i++) begin
            drv_any = drv_any | vout[i].drive;
            if (!vout[i].drive && vout[i].mv != 16'h0) mv_off_ok = 1'b0;
            if (vout[i].drive && vout[i].gnd_tie) tie_ok = 1'b0;
            if (vout[i].mv != 16'h0) mv_zero = 1'b0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_one_wait: assert property ((psel && !penable) ##1 (psel && penable)
        |-> !pready ##1 pready) else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_err_rdata: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error response carries nonzero read data");
    a_reset_dark: assert property ($rose(presetn) |-> !analog_on && !drv_any)
        else $error("outputs powered right after reset");
    a_on_follows: assert property (drv_any |-> $past(analog_on))
        else $error("channel driven while analog section off");
    a_off_follows: assert property ($fell(analog_on) |-> ##[0:2] !drv_any)
        else $error("channel still driven after analog section off");
    a_off_mv_zero: assert property (mv_off_ok)
        else $error("powered-down channel shows a level");
    a_tie_excl: assert property (tie_ok)
        else $error("driven channel also tied to ground");
    a_clear_zero: assert property ($fell(clear_input_n) |-> ##[1:8] mv_zero)
        else $error("outputs not zero after clear");
    a_oe_in_frame: assert property ($rose(serial_dout_oe) |-> !frame_sync_n)
        else $error("readback driven outside a frame");

    c_powered: cover property (drv_any && analog_on);
    c_clear: cover property ($fell(clear_input_n));
    c_readback: cover property ($rose(serial_dout_oe));
    c_refused: cover property (pready && pslverr);
endmodule

bind qdpc_top qdpc_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_sync_n(frame_sync_n), .serial_dout_oe(serial_dout_oe),
    .clear_input_n(clear_input_n), .analog_on(analog_on), .vout(vout));

// File: test/qdpc_host_model.sv
// Behavioural serial host that writes and reads 16-bit frames
`timescale 1ns/1ps
module qdpc_host_model (
    input wire logic pclk,
    input wire logic serial_dout,
    input wire logic serial_dout_oe,
    output logic frame_sync_n,
    output logic serial_clk,
    output logic serial_din
);
    initial begin
        frame_sync_n = 1'b1;
        serial_clk = 1'b0;
        serial_din = 1'b0;
    end

    // Six pclk per phase keeps clear of the three-flop sync delay
    // Fewer than 16 bits raises sync early and cuts the frame
    task automatic send(input logic [15:0] w, input int nbits, output logic [11:0] rd);
        rd = 12'h0;
        @(posedge pclk);
        frame_sync_n <= 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            @(posedge pclk);
            serial_din <= w[i];
            repeat (6) @(posedge pclk);
            serial_clk <= 1'b1;
            repeat (6) @(posedge pclk);
            serial_clk <= 1'b0;
            if (i < 12 && serial_dout_oe === 1'b1) rd[i] = serial_dout;
        end
        repeat (4) @(posedge pclk);
        frame_sync_n <= 1'b1;
        // Released data line must not keep the last bit
        serial_din <= ~w[0];
        repeat (6) @(posedge pclk);
    endtask
endmodule

// File: test/quad_dac_power_control_bench.sv
// Self-checking bench for the quad DAC power control top
`timescale 1ns/1ps
module quad_dac_power_control_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic load_n = 1'b1;
    logic clr_n = 1'b1;
    logic rsel = 1'b1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fsync_n;
    logic sclk;
    logic sdin;
    logic sdout;
    logic sdout_oe;
    logic analog_on;
    qdpc_pkg::qdpc_vout_s [3:0] vout;
    int fails = 0;
    int samples_checked = 0;
    logic [31:0] rdv;
    logic errv;
    logic [11:0] srd;

    always #5 pclk = ~pclk;

    qdpc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_sync_n(fsync_n), .serial_clk(sclk), .serial_din(sdin),
        .serial_dout(sdout), .serial_dout_oe(sdout_oe),
        .load_outputs_strobe_n(load_n), .clear_input_n(clr_n),
        .range_select(rsel), .analog_on(analog_on), .vout(vout));

    qdpc_host_model i_host (.pclk(pclk), .serial_dout(sdout),
        .serial_dout_oe(sdout_oe), .frame_sync_n(fsync_n),
        .serial_clk(sclk), .serial_din(sdin));

    task automatic close_out();
        if (fails == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            fails++;
            close_out();
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] ad(input logic [7:0] b, input int i);
        return {24'h0, b + 8'(4 * i)};
    endfunction

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        repeat (4) @(posedge pclk);
    endtask

    task automatic ser(input logic [15:0] w);
        i_host.send(w, 16, srd);
        repeat (10) @(posedge pclk);
    endtask

    task automatic vchk(input int i, input logic [15:0] mv, input logic [1:0] ld);
        chk({14'h0, vout[i]}, {14'h0, mv, ld});
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(ad(qdpc_pkg::ADDR_CTRL, 0), 32'h040);
        rd(ad(qdpc_pkg::ADDR_STAT, 0), 32'h060);
        for (int i = 0; i < 4; i++) begin
            rd(ad(qdpc_pkg::ADDR_INP, i), 32'h0);
            rd(ad(qdpc_pkg::ADDR_DAC, i), 32'h0);
        end
        rd(32'h44, 32'h0);
        chk({31'h0, errv}, 32'h1);
        ser({1'b0, qdpc_pkg::SEL_CTRL, 12'h044});
        rd(ad(qdpc_pkg::ADDR_CTRL, 0), 32'h044);
        chk({31'h0, analog_on}, 32'h1);
        ser({1'b0, 3'h2, 12'h800});
        rd(ad(qdpc_pkg::ADDR_INP, 1), 32'h800);
        rd(ad(qdpc_pkg::ADDR_DAC, 1), 32'h0);
        load_n <= 1'b0;
        repeat (8) @(posedge pclk);
        load_n <= 1'b1;
        repeat (8) @(posedge pclk);
        rd(ad(qdpc_pkg::ADDR_DAC, 1), 32'h800);
        vchk(1, 16'h0, 2'b01);
        wr(ad(qdpc_pkg::ADDR_CTRL, 0), 32'h048);
        vchk(1, 16'h3a98, 2'b10);
        vchk(0, 16'h0, 2'b01);
        wr(ad(qdpc_pkg::ADDR_CTRL, 0), 32'h008);
        vchk(0, 16'h0, 2'b00);
        rsel <= 1'b0;
        wr(ad(qdpc_pkg::ADDR_INP, 1), 32'h200);
        wr(ad(qdpc_pkg::ADDR_INP, 2), 32'hfff);
        wr(ad(qdpc_pkg::ADDR_CMD, 0), 32'h1);
        wr(ad(qdpc_pkg::ADDR_CTRL, 0), 32'h018);
        vchk(1, 16'h1d4c, 2'b10);
        vchk(2, 16'hea51, 2'b10);
        wr(ad(qdpc_pkg::ADDR_CTRL, 0), 32'h040);
        chk({31'h0, analog_on}, 32'h0);
        vchk(1, 16'h0, 2'b01);
        rd(ad(qdpc_pkg::ADDR_DAC, 1), 32'h200);
        wr(ad(qdpc_pkg::ADDR_CTRL, 0), 32'h048);
        vchk(1, 16'h1d4c, 2'b10);
        rd(ad(qdpc_pkg::ADDR_VOUT, 1), 32'h7532);
        i_host.send({1'b1, qdpc_pkg::SEL_CTRL, 12'h0}, 16, srd);
        chk({20'h0, srd}, 32'h048);
        // Sync rises before the 16th bit, so this control write must be dropped
        i_host.send({1'b0, qdpc_pkg::SEL_CTRL, 12'h000}, 15, srd);
        rd(ad(qdpc_pkg::ADDR_CTRL, 0), 32'h048);
        rd(ad(qdpc_pkg::ADDR_SER, 0), 32'h00010003);
        rd(ad(qdpc_pkg::ADDR_LAST, 0), 32'h0000f000);
        load_n <= 1'b0;
        wr(ad(qdpc_pkg::ADDR_INP, 3), 32'h123);
        rd(ad(qdpc_pkg::ADDR_DAC, 3), 32'h123);
        load_n <= 1'b1;
        clr_n <= 1'b0;
        repeat (8) @(posedge pclk);
        rd(ad(qdpc_pkg::ADDR_INP, 1), 32'h0);
        rd(ad(qdpc_pkg::ADDR_DAC, 2), 32'h0);
        vchk(1, 16'h0, 2'b10);
        clr_n <= 1'b1;
        wr(ad(qdpc_pkg::ADDR_INP, 0), 32'h5a5);
        rd(ad(qdpc_pkg::ADDR_INP, 0), 32'h5a5);
        wr(ad(qdpc_pkg::ADDR_CMD, 0), 32'h2);
        rd(ad(qdpc_pkg::ADDR_INP, 0), 32'h0);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(ad(qdpc_pkg::ADDR_CTRL, 0), 32'h040);
        close_out();
    end

    initial begin
        repeat (30000) @(posedge pclk);
        fails++;
        close_out();
    end
endmodule
